//--- dv/cal_trim_checker.sv
// checker: port assertions for the calibration and trim bank
`timescale 1ns/1ps
`default_nettype none
module cal_trim_checker
	import cal_trim_pkg::*;
#(
	parameter int WORDS = CAL_WORDS
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [7:0]  fuse_gain_a,
	input wire logic        cal_rd_strobe,
	input wire logic        cal_wr_strobe,
	input wire logic [9:0]  cal_word_index,
	input wire logic [7:0]  cal_wr_word,
	input wire logic        cal_vector_valid,
	input wire logic [7:0]  gain_adjust_chan_a,
	input wire logic [7:0]  dither_control
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic       stp;
	logic       last;
	logic [9:0] nxt;
	assign stp = cal_rd_strobe || cal_wr_strobe;
	assign last = cal_word_index == 10'(WORDS - 1);
	assign nxt = last ? 10'h000 : cal_word_index + 10'h001;
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_zero_wait: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	a_read_step_cause: assert property (cal_rd_strobe |-> psel && penable && !pwrite && ce)
		else $error("read strobe without a read access");
	a_write_word_path: assert property (cal_wr_strobe |-> pwrite && cal_wr_word == pwdata[7:0])
		else $error("write strobe with wrong word");
	a_index_next_word: assert property (stp && ce |=> cal_word_index == $past(nxt))
		else $error("word index did not step");
	a_wrap_marks_valid: assert property (stp && ce && last |=> cal_vector_valid)
		else $error("vector not valid after last word");
	a_mid_seq_invalid: assert property (stp && ce && !last |=> !cal_vector_valid)
		else $error("vector valid in mid sequence");
	a_refused_no_step: assert property (pslverr |-> !stp)
		else $error("refused access stepped the vector");
	a_fuse_load: assert property ($fell(rst) |-> ##3 gain_adjust_chan_a == fuse_gain_a)
		else $error("trim not loaded from fuse");
	a_reset_values: assert property ($fell(rst) |-> dither_control == DITHER_RESET && cal_vector_valid)
		else $error("wrong value after reset");
	c_wrap: cover property (stp && last);
	c_refused: cover property (pslverr);
	c_restore: cover property (cal_wr_strobe);
endmodule
bind cal_trim_regs cal_trim_checker #(.WORDS(WORDS)) i_chk (.clk, .rst, .ce, .psel, .penable,
	.pwrite, .pwdata, .pready, .pslverr, .fuse_gain_a, .cal_rd_strobe, .cal_wr_strobe,
	.cal_word_index, .cal_wr_word, .cal_vector_valid, .gain_adjust_chan_a, .dither_control);
`default_nettype wire

//--- dv/calibration_vector_and_trim_regs_test.sv
// testbench: apb sequences against the calibration and trim bank
`timescale 1ns/1ps
`default_nettype none
module calibration_vector_and_trim_regs_test;
	import cal_trim_pkg::*;
	// short vector keeps the run brief
	localparam int W = 5;
	localparam logic [9:0] TI[5] = '{IDX_GAIN_A, IDX_GAIN_B, IDX_BANDGAP, IDX_TERM_A, IDX_TERM_B};
	localparam logic [7:0] FG[5] = '{8'h5A, 8'hC3, 8'h09, 8'h7E, 8'h81};
	localparam logic [7:0] MK[5] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF};
	logic        clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, halted = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, ws, freeze;
	logic [7:0]  cal_rd_word = 8'h00, wr_word, sw;
	logic [9:0]  idx, si;
	logic        vv, rs;
	logic [7:0]  dq;
	wire logic [7:0] tq[5];
	wire logic [3:0] bq;
	int          nrs = 0;
	assign tq[2] = {4'h0, bq};
	always @(posedge clk) if (rs) nrs <= nrs + 1;
	int          n_errors = 0, checked = 0, i;
	always #20 clk = ~clk;
	// engine model: word at the current index
	always @(posedge clk) cal_rd_word <= idx[7:0] ^ 8'h3C;
	always @(posedge clk) if (ws) begin
		si <= idx;
		sw <= wr_word;
	end
	cal_trim_regs #(.WORDS(W)) i_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fuse_gain_a(FG[0]), .fuse_gain_b(FG[1]),
		.fuse_bandgap(FG[2][3:0]), .fuse_term_a(FG[3]), .fuse_term_b(FG[4]),
		.calibration_halted_flag(halted), .cal_rd_word(cal_rd_word), .cal_rd_strobe(rs),
		.cal_wr_strobe(ws), .cal_word_index(idx), .cal_wr_word(wr_word),
		.cal_vector_valid(vv), .address_freeze(freeze), .gain_adjust_chan_a(tq[0]),
		.gain_adjust_chan_b(tq[1]), .bandgap_adjust(bq),
		.termination_adjust_chan_a(tq[3]), .termination_adjust_chan_b(tq[4]),
		.dither_control(dq));
	task automatic final_report;
		$display("comparisons %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [9:0] ix, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			n_errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		for (i = 0; i < 5; i++) begin
			xfer(0, TI[i], 0);
			chk("fuse trim", {24'h0, FG[i] & MK[i]}, rd);
			chk("fuse pin", {24'h0, FG[i] & MK[i]}, {24'h0, tq[i]});
			xfer(1, TI[i], {24'hFFFFFF, 8'hF6 ^ FG[i]});
			xfer(0, TI[i], 0);
			chk("trim", {24'h0, (8'hF6 ^ FG[i]) & MK[i]}, rd);
			chk("trim pin", {24'h0, (8'hF6 ^ FG[i]) & MK[i]}, {24'h0, tq[i]});
		end
		// frozen bank ignores a write
		ce <= 0;
		xfer(1, IDX_GAIN_A, 0);
		ce <= 1;
		xfer(0, IDX_GAIN_A, 0);
		chk("gain held", {24'h0, 8'hF6 ^ FG[0]}, rd);
		xfer(0, IDX_DITHER, 0);
		chk("dither reset", 32'h01, rd);
		chk("dither pin reset", 32'h01, {24'h0, dq});
		xfer(1, IDX_DITHER, 32'h06);
		xfer(0, IDX_DITHER, 0);
		chk("dither", 32'h06, rd);
		chk("dither pin", 32'h06, {24'h0, dq});
		xfer(0, IDX_CAL_PORT, 0);
		chk("refused", 1, err);
		halted <= 0;
		repeat (3) @(posedge clk);
		xfer(0, IDX_CAL_STATUS, 0);
		chk("running", 32'h2, rd);
		halted <= 1;
		repeat (3) @(posedge clk);
		xfer(1, IDX_CAL_ENABLE, 1);
		for (i = 0; i < W; i++) begin
			xfer(0, IDX_CAL_PORT, 0);
			chk("cal word", {24'h0, 8'(i) ^ 8'h3C}, rd);
			if (i == 1) xfer(0, IDX_CAL_STATUS, 0);
			if (i == 1) chk("valid mid", 32'h1, rd);
			if (i == 1) chk("valid pin mid", 0, vv);
		end
		chk("read strobes", W, nrs);
		xfer(0, IDX_CAL_STATUS, 0);
		chk("valid full", 32'h3, rd);
		chk("valid pin", 1, vv);
		for (i = 0; i < W; i++) begin
			xfer(1, IDX_CAL_PORT, 32'h80 + i);
			chk("wr index", i, {22'h0, si});
			chk("wr word", 32'h80 + i, {24'h0, sw});
		end
		xfer(0, IDX_CAL_PORT, 0);
		xfer(1, IDX_CAL_ENABLE, 0);
		xfer(0, IDX_CAL_STATUS, 0);
		chk("valid abort", 32'h1, rd);
		chk("valid pin abort", 0, vv);
		xfer(1, IDX_CAL_ENABLE, 1);
		chk("rewind", 0, {22'h0, idx});
		xfer(1, IDX_STREAM_CTRL, 1);
		chk("freeze", 1, freeze);
		xfer(0, IDX_CAL_PORT, 0);
		xfer(0, IDX_CAL_PORT + 10'h001, 0);
		chk("stream word", {24'h0, 8'h3D}, rd);
		chk("stream err", 0, err);
		xfer(0, 10'h3FF, 0);
		chk("unmapped", 1, err);
		chk("unmapped data", 0, rd);
		final_report();
	end
endmodule
`default_nettype wire

//--- pkg/cal_trim_pkg.sv
// package: register map, reset values and sizes for the calibration and trim bank
package cal_trim_pkg;
	// ------------------------------------------------------------
	// register word indices (printed offsets are not all word
	// multiples, so each offset is an index and byte addr = 4*index)
	// ------------------------------------------------------------
	localparam logic [9:0] IDX_CAL_ENABLE   = 10'h070;
	localparam logic [9:0] IDX_CAL_PORT     = 10'h071;
	localparam logic [9:0] IDX_GAIN_A       = 10'h07A;
	localparam logic [9:0] IDX_GAIN_B       = 10'h07B;
	localparam logic [9:0] IDX_BANDGAP      = 10'h07C;
	localparam logic [9:0] IDX_TERM_A       = 10'h07E;
	localparam logic [9:0] IDX_TERM_B       = 10'h07F;
	localparam logic [9:0] IDX_DITHER       = 10'h09D;
	localparam logic [9:0] IDX_STREAM_CTRL  = 10'h0A0;
	localparam logic [9:0] IDX_CAL_STATUS   = 10'h0A1;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int         CAL_ENABLE_BIT   = 0;
	localparam int         ADDR_FREEZE_BIT  = 0;
	localparam int         HALTED_BIT       = 0;
	localparam int         VALID_BIT        = 1;
	localparam int         BANDGAP_MSB      = 3;
	localparam logic [7:0] DITHER_RESET     = 8'h01;
	localparam logic [7:0] CAL_ENABLE_RESET = 8'h00;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;

	// ------------------------------------------------------------
	// calibration vector length
	// ------------------------------------------------------------
	localparam int         CAL_WORDS        = 673;
	localparam int         CAL_IDX_W        = 10;
endpackage

//--- src/cal_trim_regs.sv
// calibration vector port and fuse-defaulted trim register bank on apb
//
// Contract
// (R1) each read returns next calibration word, 673
// (R2) each write loads next calibration word, 673
// (R3) address freeze keeps register address during stream
// (R4) host accesses vector only when halted; the port is not gated on halted, which only shows in status
// (R5) short sequence marks calibration contents invalid
// (R6) gain adjust a: 8-bit read/write
// (R7) gain adjust b: 8-bit read/write
// (R8) bandgap adjust 4 bits, upper reserved zero
// (R9) termination adjust a: 8-bit read/write
// (R10) termination adjust b: 8-bit read/write
// (R11) trims load fuse values at reset
// (R12) dither control at 0x9D, reset 0x01
// (R13) enable bit 0 gates vector port
// (R14) enabling access rewinds word index to zero
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module cal_trim_regs
	import cal_trim_pkg::*;
#(
	parameter int WORDS = CAL_WORDS
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  fuse_gain_a,
	input  wire logic [7:0]  fuse_gain_b,
	input  wire logic [3:0]  fuse_bandgap,
	input  wire logic [7:0]  fuse_term_a,
	input  wire logic [7:0]  fuse_term_b,
	input  wire logic        calibration_halted_flag,
	input  wire logic [7:0]  cal_rd_word,
	output logic             cal_rd_strobe,
	output logic             cal_wr_strobe,
	output logic      [9:0]  cal_word_index,
	output logic      [7:0]  cal_wr_word,
	output logic             cal_vector_valid,
	output logic             address_freeze,
	output logic      [7:0]  gain_adjust_chan_a,
	output logic      [7:0]  gain_adjust_chan_b,
	output logic      [3:0]  bandgap_adjust,
	output logic      [7:0]  termination_adjust_chan_a,
	output logic      [7:0]  termination_adjust_chan_b,
	output logic      [7:0]  dither_control
);

	// ------------------------------------------------------------
	// synchronisers for pins from outside the clock domain
	// ------------------------------------------------------------
	logic halted_s1_reg;
	logic halted_s2_reg;
	logic [35:0] fuse_s1_reg;
	logic [35:0] fuse_s2_reg;

	// halted comes from the engine's own timing, so it is synchronised
	always_ff @(posedge clk) begin
		if (rst) begin
			halted_s1_reg <= 1'b0;
			halted_s2_reg <= 1'b0;
		end else if (ce) begin
			halted_s1_reg <= calibration_halted_flag;
			halted_s2_reg <= halted_s1_reg;
		end
	end

	// fuse levels keep sampling through reset, so the synchronised
	// value is settled when the trims load on the first edge after it
	always_ff @(posedge clk) begin
		if (ce) begin
			fuse_s1_reg <= {fuse_gain_a, fuse_gain_b, fuse_bandgap, fuse_term_a, fuse_term_b};
			fuse_s2_reg <= fuse_s1_reg;
		end
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	// word-aligned only: an address off the word boundary is unmapped
	function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
		hit = (a[11:2] == idx) && (a[1:0] == 2'b00);
	endfunction

	logic access;
	logic wr_acc;
	logic rd_acc;
	logic vec_hit;
	logic mapped;
	logic setup;

	// zero wait states: read data and refusal are registered in the
	// setup cycle, so the access phase never has to stall
	assign pready  = 1'b1;
	assign setup   = psel && !penable && ce;
	assign access  = psel && penable && ce;
	assign wr_acc  = access && pwrite;
	assign rd_acc  = access && !pwrite;

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic       fuse_load_reg;
	logic       fuse_load_next;
	logic [7:0] cal_en_reg;
	logic [7:0] cal_en_next;
	logic       freeze_reg;
	logic       freeze_next;
	logic [7:0] gain_a_reg;
	logic [7:0] gain_a_next;
	logic [7:0] gain_b_reg;
	logic [7:0] gain_b_next;
	logic [3:0] bg_reg;
	logic [3:0] bg_next;
	logic [7:0] term_a_reg;
	logic [7:0] term_a_next;
	logic [7:0] term_b_reg;
	logic [7:0] term_b_next;
	logic [7:0] dith_reg;
	logic [7:0] dith_next;
	logic [9:0] idx_reg;
	logic [9:0] idx_next;
	logic       valid_reg;
	logic       valid_next;
	logic       busy_reg;
	logic       busy_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic       err_reg;
	logic       err_next;
	logic       vec_ok;

	// a streaming master steps its address; freeze folds the next
	// index back onto the port while a sequence is open
	// (R3) freeze holds the vector port address in streams
	assign vec_hit = hit(paddr, IDX_CAL_PORT)
		|| (freeze_reg && busy_reg && hit(paddr, IDX_CAL_PORT + 10'd1));
	// (R13) port gated by enable bit 0
	assign vec_ok  = vec_hit && cal_en_reg[CAL_ENABLE_BIT];
	// status and stream control are local additions to the map
	assign mapped  = hit(paddr, IDX_CAL_ENABLE) || vec_hit || hit(paddr, IDX_GAIN_A)
		|| hit(paddr, IDX_GAIN_B) || hit(paddr, IDX_BANDGAP) || hit(paddr, IDX_TERM_A)
		|| hit(paddr, IDX_TERM_B) || hit(paddr, IDX_DITHER) || hit(paddr, IDX_STREAM_CTRL)
		|| hit(paddr, IDX_CAL_STATUS);

	// ------------------------------------------------------------
	// read data decode
	// ------------------------------------------------------------
	function automatic logic [31:0] rdata_mux();
		rdata_mux = '0;
		if (hit(paddr, IDX_CAL_ENABLE)) rdata_mux = {24'h000000, cal_en_reg};
		if (hit(paddr, IDX_GAIN_A)) rdata_mux = {24'h000000, gain_a_reg};
		if (hit(paddr, IDX_GAIN_B)) rdata_mux = {24'h000000, gain_b_reg};
		if (hit(paddr, IDX_BANDGAP)) rdata_mux = {28'h0000000, bg_reg};
		if (hit(paddr, IDX_TERM_A)) rdata_mux = {24'h000000, term_a_reg};
		if (hit(paddr, IDX_TERM_B)) rdata_mux = {24'h000000, term_b_reg};
		if (hit(paddr, IDX_DITHER)) rdata_mux = {24'h000000, dith_reg};
		if (hit(paddr, IDX_STREAM_CTRL)) rdata_mux = {31'h00000000, freeze_reg};
		if (hit(paddr, IDX_CAL_STATUS)) rdata_mux = {30'h00000000, valid_reg, halted_s2_reg};
	endfunction

	always_comb begin
		fuse_load_next = 1'b0;
		cal_en_next    = cal_en_reg;
		freeze_next    = freeze_reg;
		gain_a_next    = gain_a_reg;
		gain_b_next    = gain_b_reg;
		bg_next        = bg_reg;
		term_a_next    = term_a_reg;
		term_b_next    = term_b_reg;
		dith_next      = dith_reg;
		idx_next       = idx_reg;
		valid_next     = valid_reg;
		busy_next      = busy_reg;
		rdata_next     = rdata_reg;
		err_next       = 1'b0;
		// (R11) fuse values load once after reset
		if (fuse_load_reg) begin
			{gain_a_next, gain_b_next, bg_next, term_a_next, term_b_next} = fuse_s2_reg;
		end
		// a setup cycle with ce low captures nothing, so ce must stay high
		// from setup to the end of a read for its data to be fresh
		if (setup) begin
			err_next   = !mapped || (vec_hit && !vec_ok);
			rdata_next = '0;
			if (!pwrite) rdata_next = vec_ok ? {24'h000000, cal_rd_word} : rdata_mux();
		end
		if (wr_acc) begin
			if (hit(paddr, IDX_CAL_ENABLE)) begin
				// reserved enable bits always read back zero
				cal_en_next = {7'h00, pwdata[CAL_ENABLE_BIT]};
				// (R14) rising enable rewinds index
				if (pwdata[CAL_ENABLE_BIT] && !cal_en_reg[CAL_ENABLE_BIT]) begin
					idx_next  = '0;
					busy_next = 1'b0;
				end
				// (R5) leaving before 673 words invalidates
				if (!pwdata[CAL_ENABLE_BIT] && busy_reg) begin
					valid_next = 1'b0;
					busy_next  = 1'b0;
				end
			end
			// (R6) gain a write
			if (hit(paddr, IDX_GAIN_A)) gain_a_next = pwdata[7:0];
			// (R7) gain b write
			if (hit(paddr, IDX_GAIN_B)) gain_b_next = pwdata[7:0];
			// (R8) reserved upper bits dropped
			if (hit(paddr, IDX_BANDGAP)) bg_next = pwdata[BANDGAP_MSB:0];
			// (R9) termination a write
			if (hit(paddr, IDX_TERM_A)) term_a_next = pwdata[7:0];
			// (R10) termination b write
			if (hit(paddr, IDX_TERM_B)) term_b_next = pwdata[7:0];
			// (R12) dither control write
			if (hit(paddr, IDX_DITHER)) dith_next = pwdata[7:0];
			if (hit(paddr, IDX_STREAM_CTRL)) freeze_next = pwdata[ADDR_FREEZE_BIT];
		end
		// (R1) (R2) each port access steps the word index; a refused
		// access does not, so a retry after enabling starts in step
		if (access && vec_ok) begin
			if (idx_reg == 10'(WORDS - 1)) begin
				idx_next   = '0;
				busy_next  = 1'b0;
				valid_next = 1'b1;
			end else begin
				idx_next   = idx_reg + 10'd1;
				busy_next  = 1'b1;
				valid_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fuse_load_reg <= 1'b1;
			cal_en_reg    <= CAL_ENABLE_RESET;
			freeze_reg    <= 1'b0;
			gain_a_reg    <= ZERO_BYTE;
			gain_b_reg    <= ZERO_BYTE;
			bg_reg        <= 4'h0;
			term_a_reg    <= ZERO_BYTE;
			term_b_reg    <= ZERO_BYTE;
			dith_reg      <= DITHER_RESET;
			idx_reg       <= '0;
			// nothing has been cut short yet, so contents start valid
			valid_reg     <= 1'b1;
			busy_reg      <= 1'b0;
			rdata_reg     <= '0;
			err_reg       <= 1'b0;
		end else if (ce) begin
			// (R11) one-shot: trims take the fuse value once, then software owns them
			fuse_load_reg <= fuse_load_next;
			cal_en_reg    <= cal_en_next;
			freeze_reg    <= freeze_next;
			gain_a_reg    <= gain_a_next;
			gain_b_reg    <= gain_b_next;
			bg_reg        <= bg_next;
			term_a_reg    <= term_a_next;
			term_b_reg    <= term_b_next;
			dith_reg      <= dith_next;
			idx_reg       <= idx_next;
			valid_reg     <= valid_next;
			busy_reg      <= busy_next;
			rdata_reg     <= rdata_next;
			err_reg       <= err_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// both were fixed in the setup cycle and hold through the access phase
	assign prdata  = rdata_reg;
	assign pslverr = psel && penable && err_reg;

	// (R1) (R2) strobes mark the word taken or loaded this edge
	assign cal_rd_strobe             = rd_acc && vec_ok;
	assign cal_wr_strobe             = wr_acc && vec_ok;
	// live bus data: valid only alongside cal_wr_strobe
	assign cal_wr_word               = pwdata[7:0];
	assign cal_word_index            = idx_reg;
	assign cal_vector_valid          = valid_reg;
	assign address_freeze            = freeze_reg;
	assign gain_adjust_chan_a        = gain_a_reg;
	assign gain_adjust_chan_b        = gain_b_reg;
	assign bandgap_adjust            = bg_reg;
	assign termination_adjust_chan_a = term_a_reg;
	assign termination_adjust_chan_b = term_b_reg;
	assign dither_control            = dith_reg;

endmodule

`default_nettype wire
